// ===== fifo_pkg.sv
// constants, codes and register map of the pointer-synchronised fifo controller
package fifo_pkg;

   // ***************************************************
   // geometry
   // ***************************************************
   localparam int DATA_W        = 36;
   localparam int CELL_LOG2     = 12;
   localparam int DEPTH_LOG2    = 4;
   localparam int MAX_LOG2      = CELL_LOG2 + DEPTH_LOG2;
   localparam int CODE_W        = 3;
   localparam int EFF_W         = 5;

   // ***************************************************
   // width codes and the largest depth code (shared by writer and reader)
   // ***************************************************
   localparam logic [2:0] WID_1X4K    = 3'h0;
   localparam logic [2:0] WID_2X2K    = 3'h1;
   localparam logic [2:0] WID_4X1K    = 3'h2;
   localparam logic [2:0] WID_9X512   = 3'h3;
   localparam logic [2:0] WID_18X256  = 3'h4;
   localparam logic [2:0] WID_36X128  = 3'h5;
   localparam logic [2:0] DEP_MAX     = 3'h4;

   // ***************************************************
   // register map, byte addresses
   // ***************************************************
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_IRQ_STS  = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;

   localparam int CTRL_WID_LSB  = 0;
   localparam int CTRL_DEP_LSB  = 4;
   localparam int STS_EMPTY     = 0;
   localparam int STS_FULL      = 1;
   localparam int IRQ_OVF       = 0;
   localparam int IRQ_UNF       = 1;
   localparam int IRQ_W         = 2;

   localparam logic [2:0] CTRL_WID_RST = WID_1X4K;
   localparam logic [2:0] CTRL_DEP_RST = 3'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;

   // data bits that a width code keeps
   function automatic logic [DATA_W-1:0] width_mask(input logic [2:0] code);
      unique case (code)
         WID_1X4K:   width_mask = 36'h000000001;
         WID_2X2K:   width_mask = 36'h000000003;
         WID_4X1K:   width_mask = 36'h00000000f;
         WID_9X512:  width_mask = 36'h0000001ff;
         WID_18X256: width_mask = 36'h00003ffff;
         WID_36X128: width_mask = 36'hfffffffff;
         default:    width_mask = 36'h000000000;
      endcase
   endfunction

   function automatic logic code_reserved(input logic [2:0] wid, input logic [2:0] dep);
      code_reserved = (wid > WID_36X128) || (dep > DEP_MAX);
   endfunction

endpackage

// ===== ptr_sync.sv
// two register stages that carry a pointer into the comparing domain
`timescale 1ns/100ps
module ptr_sync #(
   parameter int W = 17
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         flush,
   input  wire logic [W-1:0] ptr_in,
   output logic      [W-1:0] ptr_out
);

   logic [W-1:0] stage1_q;

   // stage one is read by stage two only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1_q <= '0;
         ptr_out  <= '0;
      end else if (flush) begin
         stage1_q <= '0;
         ptr_out  <= '0;
      end else begin
         stage1_q <= ptr_in;
         ptr_out  <= stage1_q;
      end
   end

endmodule

// ===== fifo_ctrl.sv
// fifo controller top: apb registers, pointers, flags, storage, interrupt
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module fifo_ctrl
   import fifo_pkg::*;
#(
   parameter int CELL_L2  = CELL_LOG2,
   parameter int DEPTH_L2 = DEPTH_LOG2
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              wr_valid,
   input  wire logic [DATA_W-1:0] wr_data,
   output logic                   wr_ready,
   output logic                   rd_valid,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              rd_ready,
   output logic                   empty,
   output logic                   full,
   output logic                   irq
);

   localparam int AW = CELL_L2 + DEPTH_L2;
   localparam int PW = AW + 1;

   // ***************************************************
   // configuration and bus decode
   // ***************************************************
   logic [2:0]       wid_q;
   logic [2:0]       dep_q;
   logic [IRQ_W-1:0] imask_q;
   logic [IRQ_W-1:0] ists_q;
   logic             setup;
   logic             access;
   logic             wr_ctrl;
   logic             cfg_bad;
   logic             flush;
   logic             mapped;
   logic [2:0]       new_wid;
   logic [2:0]       new_dep;

   assign setup   = psel && !penable;
   assign access  = psel && penable && pready;
   assign new_wid = pwdata[CTRL_WID_LSB +: CODE_W];
   assign new_dep = pwdata[CTRL_DEP_LSB +: CODE_W];
   assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                    (paddr == OFS_IRQ_STS) || (paddr == OFS_IRQ_MASK);
   assign cfg_bad = code_reserved(new_wid, new_dep);
   assign wr_ctrl = access && pwrite && (paddr == OFS_CTRL) && !cfg_bad;
   // reshaping mid-stream would scramble words, so a new shape flushes
   assign flush   = wr_ctrl;

   // no wait state: pready comes from a flop fed by setup, high in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !mapped || (pwrite && (paddr == OFS_CTRL) && cfg_bad);
      end else begin
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wid_q <= CTRL_WID_RST;
         dep_q <= CTRL_DEP_RST;
      end else if (wr_ctrl) begin
         wid_q <= new_wid;
         dep_q <= new_dep;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask_q <= IRQ_MASK_RST;
      end else if (access && pwrite && (paddr == OFS_IRQ_MASK)) begin
         imask_q <= pwdata[IRQ_W-1:0];
      end
   end

   // ***************************************************
   // pointers
   // ***************************************************
   logic [EFF_W-1:0] eff;
   logic [PW-1:0]    wptr_q;
   logic [PW-1:0]    rptr_q;
   logic [PW-1:0]    wptr_d;
   logic [PW-1:0]    rptr_d;
   logic [PW-1:0]    wsync;
   logic [PW-1:0]    rsync;
   logic             wr_fire;
   logic             rd_fire;

   // depth code doubles cells per step
   assign eff = EFF_W'(CELL_L2) - EFF_W'(wid_q) + EFF_W'(dep_q);

   // wrap bit sits above the live address bits
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p, input logic [EFF_W-1:0] e);
      logic [AW-1:0] mask;
      logic [AW-1:0] a;
      logic          w;
      mask = ~({AW{1'b1}} << e);
      a    = p[AW-1:0] & mask;
      w    = p[AW];
      if (a == mask) begin
         w = ~w;
      end
      a = (a + {{(AW-1){1'b0}}, 1'b1}) & mask;
      ptr_inc = {w, a};
   endfunction

   assign wr_fire = wr_valid && wr_ready;
   assign rd_fire = rd_ready && rd_valid;
   assign wptr_d  = flush ? '0 : (wr_fire ? ptr_inc(wptr_q, eff) : wptr_q);
   assign rptr_d  = flush ? '0 : (rd_fire ? ptr_inc(rptr_q, eff) : rptr_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_q <= '0;
      end else begin
         wptr_q <= wptr_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rptr_q <= '0;
      end else begin
         rptr_q <= rptr_d;
      end
   end

   ptr_sync #(.W(PW)) u_wsync (
      .pclk    (pclk),
      .presetn (presetn),
      .flush   (flush),
      .ptr_in  (wptr_q),
      .ptr_out (wsync)
   );

   ptr_sync #(.W(PW)) u_rsync (
      .pclk    (pclk),
      .presetn (presetn),
      .flush   (flush),
      .ptr_in  (rptr_q),
      .ptr_out (rsync)
   );

   // ***************************************************
   // flags
   // ***************************************************
   logic          empty_d;
   logic          full_d;
   logic          addr_eq;
   logic          wrap_ne;

   // only the second sync stage is compared; a stale sync only delays a flag
   assign addr_eq = (wptr_d[AW-1:0] == rsync[AW-1:0]);
   assign wrap_ne = (wptr_d[AW] != rsync[AW]);
   // empty on equal pointers, at once on flush
   assign empty_d = flush || (rptr_d == wsync);
   // full on address match, wrap differs
   assign full_d  = !flush && addr_eq && wrap_ne;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         empty    <= 1'b1;
         full     <= 1'b0;
         rd_valid <= 1'b0;
         wr_ready <= 1'b0;
      end else begin
         empty    <= empty_d;
         full     <= full_d;
         rd_valid <= !empty_d;
         wr_ready <= !full_d;
      end
   end

   // ***************************************************
   // storage
   // ***************************************************
   logic [DATA_W-1:0] mem_q [2**AW];

   always_ff @(posedge pclk) begin
      if (wr_fire && !flush) begin
         mem_q[wptr_q[AW-1:0]] <= wr_data & width_mask(wid_q);
      end
   end

   // show-ahead: word under the next read address, always old enough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_q[rptr_d[AW-1:0]];
      end
   end

   // ***************************************************
   // interrupts and read data
   // ***************************************************
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] ists_d;
   logic             rd_ists;

   assign ev[IRQ_OVF] = wr_valid && !wr_ready;
   assign ev[IRQ_UNF] = rd_ready && !rd_valid;
   assign rd_ists     = access && !pwrite && (paddr == OFS_IRQ_STS);
   // set beats the read clear
   assign ists_d      = (rd_ists ? '0 : ists_q) | ev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ists_q <= '0;
         irq    <= 1'b0;
      end else begin
         ists_q <= ists_d;
         irq    <= |(ists_d & imask_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup && !pwrite) begin
         prdata <= '0;
         unique case (paddr)
            OFS_CTRL: begin
               prdata[CTRL_WID_LSB +: CODE_W] <= wid_q;
               prdata[CTRL_DEP_LSB +: CODE_W] <= dep_q;
            end
            OFS_STATUS: begin
               prdata[STS_EMPTY] <= empty;
               prdata[STS_FULL]  <= full;
            end
            OFS_IRQ_STS:  prdata[IRQ_W-1:0] <= ists_q;
            OFS_IRQ_MASK: prdata[IRQ_W-1:0] <= imask_q;
            default:      prdata <= '0;
         endcase
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   property p_empty_eq;
      empty == ($past(flush) || (rptr_q == $past(wsync)));
   endproperty
   a_empty_eq: assert property (p_empty_eq) else $error("empty flag disagrees with pointers");

   property p_full_eq;
      full == (!$past(flush) && (wptr_q[AW-1:0] == $past(rsync[AW-1:0])) &&
               (wptr_q[AW] != $past(rsync[AW])));
   endproperty
   a_full_eq: assert property (p_full_eq) else $error("full flag disagrees with pointers");

   property p_wsync_lag;
      (!flush && !$past(flush) && !$past(flush, 2)) |-> (wsync == $past(wptr_q, 2));
   endproperty
   a_wsync_lag: assert property (p_wsync_lag) else $error("write pointer not two stages late");

   property p_rsync_lag;
      (!flush && !$past(flush) && !$past(flush, 2)) |-> (rsync == $past(rptr_q, 2));
   endproperty
   a_rsync_lag: assert property (p_rsync_lag) else $error("read pointer not two stages late");

   property p_block_full;
      (full && !flush) |=> $stable(wptr_q);
   endproperty
   a_block_full: assert property (p_block_full) else $error("write taken while full");

   property p_wrap_toggle;
      (wr_fire && !flush && ((wptr_q[AW-1:0] & ~({AW{1'b1}} << eff)) == ~({AW{1'b1}} << eff)))
         |=> (wptr_q[AW] != $past(wptr_q[AW])) && (wptr_q[AW-1:0] == '0);
   endproperty
   a_wrap_toggle: assert property (p_wrap_toggle) else $error("wrap bit not toggled at end");

   property p_flag_stable;
      !$past(flush) && !$past(flush, 2) && $stable(rptr_q) &&
         ($past(wsync) == $past(wsync, 2)) |-> $stable(empty);
   endproperty
   a_flag_stable: assert property (p_flag_stable) else $error("empty moved with quiet pointers");

   property p_reserved;
      (s_setup and (pwrite && (paddr == OFS_CTRL) && (pwdata[CTRL_WID_LSB + 1 +: 2] == 2'h3)))
         ##1 s_access |=> $stable(wid_q) ##0 (pslverr || $past(pslverr));
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved width code accepted");

   property p_depth;
      (wid_q == WID_36X128 && dep_q == DEP_MAX) |->
         (eff == EFF_W'(CELL_L2 + int'(DEP_MAX) - int'(WID_36X128)));
   endproperty
   a_depth: assert property (p_depth) else $error("cascade depth miscomputed");

   property p_irq;
      ##1 (irq == |($past(ists_d) & $past(imask_q)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not following masked status");

endmodule

// ===== fifo_user.sv
// writer and reader user logic on the far side of the fifo controller
`timescale 1ns/100ps
module fifo_user
   import fifo_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              wr_ready,
   input  wire logic              rd_valid,
   input  wire logic [DATA_W-1:0] rd_data,
   output logic                   wr_valid,
   output logic      [DATA_W-1:0] wr_data,
   output logic                   rd_ready
);
   initial begin
      wr_valid = 1'b0;
      wr_data  = '0;
      rd_ready = 1'b0;
   end

   // ***************************************************
   // writer
   // ***************************************************
   // one word width
   task automatic push(input logic [DATA_W-1:0] d, output bit ok);
      logic tk;
      wr_valid <= 1'b1;
      wr_data  <= d;
      ok = 1'b0;
      repeat (50) begin
         @(negedge pclk);
         tk = wr_ready;
         @(posedge pclk);
         if (tk) begin
            ok = 1'b1;
            break;
         end
      end
   endtask

   // keeps offering past full, so overflow is provoked on purpose
   task automatic fill(output int n);
      logic tk;
      wr_valid <= 1'b1;
      wr_data  <= '0;
      n = 0;
      repeat (24) begin
         @(negedge pclk);
         tk = wr_ready;
         @(posedge pclk);
         if (tk) begin
            n++;
            wr_data <= DATA_W'(n);
         end
      end
   endtask

   // released data shows the inverse, never the last word
   task automatic wr_idle();
      wr_valid <= 1'b0;
      wr_data  <= ~wr_data;
   endtask

   // ***************************************************
   // reader
   // ***************************************************
   task automatic pop(output logic [DATA_W-1:0] got, output bit ok);
      logic tk;
      rd_ready <= 1'b1;
      ok = 1'b0;
      repeat (50) begin
         @(negedge pclk);
         tk  = rd_valid;
         got = rd_data;
         @(posedge pclk);
         if (tk) begin
            ok = 1'b1;
            break;
         end
      end
   endtask

   task automatic rd_idle();
      rd_ready <= 1'b0;
   endtask

   // one read attempt for a single cycle, used against an empty fifo
   task automatic poke();
      rd_ready <= 1'b1;
      @(posedge pclk);
      rd_ready <= 1'b0;
   endtask
endmodule

// ===== dual_clock_fifo_controller_tb_top.sv
// self-checking testbench of the fifo controller
`timescale 1ns/100ps
module dual_clock_fifo_controller_tb_top
   import fifo_pkg::*;
;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              wr_valid;
   logic [DATA_W-1:0] wr_data;
   logic              wr_ready;
   logic              rd_valid;
   logic [DATA_W-1:0] rd_data;
   logic              rd_ready;
   logic              empty;
   logic              full;
   logic              irq;
   int                n_mismatch;
   int                n_tests;
   int                cyc;
   logic [DATA_W-1:0] wmask [6] = '{36'h1, 36'h3, 36'hf, 36'h1ff, 36'h3ffff, 36'hfffffffff};

   // small memory keeps the run short; depth math follows CELL_L2
   fifo_ctrl #(.CELL_L2(6), .DEPTH_L2(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
      .empty(empty), .full(full), .irq(irq));

   fifo_user u_user (.pclk(pclk), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .wr_valid(wr_valid), .wr_data(wr_data), .rd_ready(rd_ready));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ***************************************************
   // helpers
   // ***************************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // setup, then access held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      logic rdy;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      rdy = 1'b0;
      repeat (20) begin
         @(negedge pclk);
         rdy = pready;
         rd  = prdata;
         err = pslverr;
         @(posedge pclk);
         if (rdy) break;
      end
      chk(36'(rdy), 36'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset();
      logic [31:0] rd;
      logic        er;
      chk({empty, full, irq, wr_ready}, 36'h9);
      apb(1'b0, OFS_CTRL, 32'h0, rd, er);
      chk({rd, er}, 36'h0);
      apb(1'b0, OFS_IRQ_MASK, 32'h0, rd, er);
      chk({rd, er}, 36'h0);
      apb(1'b0, 8'h10, 32'h0, rd, er);
      chk({rd, er}, 36'h1);
      $display("reset test done");
   endtask

   task automatic t_width();
      logic [31:0]       rd;
      logic              er;
      logic [DATA_W-1:0] got;
      bit                ok;
      for (int w = 0; w < 6; w++) begin
         apb(1'b1, OFS_CTRL, 32'(w), rd, er);
         u_user.push(36'hfffffffff, ok);
         u_user.wr_idle();
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         chk(36'(empty), 36'h1);
         @(posedge pclk);
         @(negedge pclk);
         chk(36'(empty), 36'h0);
         @(posedge pclk);
         u_user.pop(got, ok);
         u_user.rd_idle();
         chk(got, wmask[w]);
      end
      for (int c = 6; c < 8; c++) begin
         apb(1'b1, OFS_CTRL, 32'(c), rd, er);
         chk(36'(er), 36'h1);
      end
      apb(1'b1, OFS_CTRL, 32'h55, rd, er);
      chk(36'(er), 36'h1);
      apb(1'b0, OFS_CTRL, 32'h0, rd, er);
      chk(36'(rd), 36'h5);
      apb(1'b1, OFS_CTRL, 32'h45, rd, er);
      chk(36'(er), 36'h0);
      apb(1'b0, OFS_CTRL, 32'h0, rd, er);
      chk(36'(rd), 36'h45);
      $display("width test done");
   endtask

   task automatic t_depth();
      logic [31:0]       rd;
      logic              er;
      logic [DATA_W-1:0] got;
      bit                ok;
      int                n;
      for (int d = 0; d < 3; d++) begin
         apb(1'b1, OFS_CTRL, 32'((d << 4) | 5), rd, er);
         repeat (2) begin
            u_user.fill(n);
            u_user.wr_idle();
            chk(36'(n), 36'(2 << d));
            chk({full, wr_ready}, 36'h2);
            for (int k = 0; k < n; k++) begin
               u_user.pop(got, ok);
               chk(got, 36'(k));
            end
            u_user.rd_idle();
         end
      end
      $display("depth test done");
   endtask

   task automatic t_irq();
      logic [31:0]       rd;
      logic              er;
      logic [DATA_W-1:0] got;
      bit                ok;
      int                n;
      apb(1'b1, OFS_IRQ_MASK, 32'h3, rd, er);
      apb(1'b1, OFS_CTRL, 32'h5, rd, er);
      u_user.fill(n);
      u_user.wr_idle();
      @(posedge pclk);
      chk(36'(irq), 36'h1);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      chk(36'(rd), 36'h2);
      apb(1'b0, OFS_IRQ_STS, 32'h0, rd, er);
      chk(36'(rd), 36'h1);
      apb(1'b0, OFS_IRQ_STS, 32'h0, rd, er);
      chk({rd, irq}, 36'h0);
      u_user.pop(got, ok);
      u_user.rd_idle();
      repeat (3) begin
         @(negedge pclk);
         chk(36'(full), 36'h1);
         @(posedge pclk);
      end
      @(negedge pclk);
      chk(36'(full), 36'h0);
      @(posedge pclk);
      apb(1'b1, OFS_IRQ_MASK, 32'h0, rd, er);
      u_user.pop(got, ok);
      u_user.rd_idle();
      repeat (5) @(posedge pclk);
      u_user.poke();
      @(negedge pclk);
      chk(36'(irq), 36'h0);
      @(posedge pclk);
      apb(1'b0, OFS_IRQ_STS, 32'h0, rd, er);
      chk(36'(rd), 36'h2);
      $display("interrupt test done");
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      @(posedge pclk);
      t_reset();
      t_width();
      t_depth();
      t_irq();
      print_verdict();
   end
endmodule
